//--- arfwd_core.sv
`timescale 1ns/1ps
module arfwd_core (
  input  wire logic       mclk,
  input  wire logic       req,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_data,
  output logic            sfr_wr,
  output logic      [7:0] sfr_addr,
  output logic      [7:0] sfr_wdata
);
  // core side: one write strobe per request, launched at the falling edge
  always @(negedge mclk) begin
    sfr_wr    <= req;
    sfr_addr  <= req_addr;
    sfr_wdata <= req_data;
  end
endmodule

//--- arfwd_pkg.sv
package arfwd_pkg;
  localparam logic [7:0] ADDR_UPPER_LIMIT_LOW  = 8'hc4;
  localparam logic [7:0] ADDR_UPPER_LIMIT_HIGH = 8'hc5;
  localparam logic [7:0] ADDR_LOWER_LIMIT_LOW  = 8'hc6;
  localparam logic [7:0] ADDR_LOWER_LIMIT_HIGH = 8'hc7;
  localparam logic [7:0] RST_UPPER_LIMIT       = 8'hff;
  localparam logic [7:0] RST_LOWER_LIMIT       = 8'h00;
  localparam logic [15:0] RST_RESULT           = 16'h0000;
  localparam int RES_BITS = 12;
  localparam int NIB_POS  = 4;
endpackage

//--- arfwd_top.sv
`timescale 1ns/1ps
module arfwd_top (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_code,
  input  wire logic        differential,
  input  wire logic        left_justify_select,
  input  wire logic        flag_clear,
  output logic      [7:0]  result_high_byte,
  output logic      [7:0]  result_low_byte,
  output logic             window_match_flag
);
  // ****************************************
  // formatting
  // ****************************************
  logic [15:0] fmt_word;
  logic [15:0] upper_limit;
  logic [15:0] lower_limit;
  logic [7:0]  ul_lo;
  logic [7:0]  ul_hi;
  logic [7:0]  ll_lo;
  logic [7:0]  ll_hi;
  logic        match;

  function automatic logic [15:0] fmt(input logic [11:0] c,
                                      input logic d, input logic lj);
    if (lj)
      fmt = {c, 4'h0};
    else
      fmt = {{4{d & c[11]}}, c};
  endfunction

  assign fmt_word = fmt(conv_code, differential, left_justify_select);

  always_ff @(posedge mclk) begin
    if (rst) begin
      result_high_byte <= arfwd_pkg::RST_RESULT[15:8];
      result_low_byte  <= arfwd_pkg::RST_RESULT[7:0];
    end else if (conv_done) begin
      result_high_byte <= fmt_word[15:8];
      result_low_byte  <= fmt_word[7:0];
    end
  end

  // ****************************************
  // limit registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      ul_lo <= arfwd_pkg::RST_UPPER_LIMIT;
      ul_hi <= arfwd_pkg::RST_UPPER_LIMIT;
      ll_lo <= arfwd_pkg::RST_LOWER_LIMIT;
      ll_hi <= arfwd_pkg::RST_LOWER_LIMIT;
    end else if (sfr_wr) begin
      case (sfr_addr)
        arfwd_pkg::ADDR_UPPER_LIMIT_LOW:  ul_lo <= sfr_wdata;
        arfwd_pkg::ADDR_UPPER_LIMIT_HIGH: ul_hi <= sfr_wdata;
        arfwd_pkg::ADDR_LOWER_LIMIT_LOW:  ll_lo <= sfr_wdata;
        arfwd_pkg::ADDR_LOWER_LIMIT_HIGH: ll_hi <= sfr_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    sfr_hit = 1'b1;
    case (sfr_addr)
      arfwd_pkg::ADDR_UPPER_LIMIT_LOW:  sfr_rdata = ul_lo;
      arfwd_pkg::ADDR_UPPER_LIMIT_HIGH: sfr_rdata = ul_hi;
      arfwd_pkg::ADDR_LOWER_LIMIT_LOW:  sfr_rdata = ll_lo;
      arfwd_pkg::ADDR_LOWER_LIMIT_HIGH: sfr_rdata = ll_hi;
      default: begin
        sfr_rdata = 8'h00;
        sfr_hit   = 1'b0;
      end
    endcase
  end

  assign upper_limit = {ul_hi, ul_lo};
  assign lower_limit = {ll_hi, ll_lo};

  // ****************************************
  // window detector
  // ****************************************
  always_comb begin
    logic gt;
    logic lt;
    gt = 1'b0;
    lt = 1'b0;
    if (differential) begin
      gt = $signed(fmt_word) > $signed(upper_limit);
      lt = $signed(fmt_word) < $signed(lower_limit);
    end else begin
      gt = fmt_word > upper_limit;
      lt = fmt_word < lower_limit;
    end
    if (differential ? ($signed(lower_limit) > $signed(upper_limit))
                     : (lower_limit > upper_limit))
      match = gt & lt;
    else
      match = gt | lt;
  end

  // set wins over clear
  always_ff @(posedge mclk) begin
    if (rst)
      window_match_flag <= 1'b0;
    else if (conv_done && match)
      window_match_flag <= 1'b1;
    else if (flag_clear)
      window_match_flag <= 1'b0;
  end

  // ****************************************
  // checks
  // ****************************************
  property p_flag_set;
    @(posedge mclk) disable iff (rst)
      conv_done && match |=> window_match_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("match did not set flag");

  property p_flag_hold;
    @(posedge mclk) disable iff (rst)
      window_match_flag && !flag_clear |=> window_match_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag cleared by hardware");

  property p_lj_low;
    @(posedge mclk) disable iff (rst)
      conv_done && left_justify_select |=> result_low_byte[3:0] == 4'h0
        && result_high_byte == $past(conv_code[11:4]);
  endproperty
  a_lj_low: assert property (p_lj_low)
    else $error("left justified layout wrong");

  property p_rj;
    @(posedge mclk) disable iff (rst)
      conv_done && !left_justify_select |=>
        {result_high_byte, result_low_byte} ==
        {{4{$past(differential) & $past(conv_code[11])}}, $past(conv_code)};
  endproperty
  a_rj: assert property (p_rj)
    else $error("right justified layout wrong");

  property p_lj_nibble;
    @(posedge mclk) disable iff (rst)
      conv_done && left_justify_select |=>
        result_low_byte[7:4] == $past(conv_code[3:0]);
  endproperty
  a_lj_nibble: assert property (p_lj_nibble)
    else $error("left justified low nibble wrong");

  property p_rj_zero_fill;
    @(posedge mclk) disable iff (rst)
      conv_done && !left_justify_select && !differential |=>
        result_high_byte[7:4] == 4'h0;
  endproperty
  a_rj_zero_fill: assert property (p_rj_zero_fill)
    else $error("single ended upper nibble not zero");

  property p_result_hold;
    @(posedge mclk) disable iff (rst)
      !conv_done |=> $stable({result_high_byte, result_low_byte});
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without conversion");

  // ****************************************
  // flag checks
  // ****************************************
  property p_flag_clear;
    @(posedge mclk) disable iff (rst)
      flag_clear && !(conv_done && match) |=> !window_match_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag clear not taken");

  property p_flag_quiet;
    @(posedge mclk) disable iff (rst)
      !window_match_flag && !(conv_done && match) |=> !window_match_flag;
  endproperty
  a_flag_quiet: assert property (p_flag_quiet)
    else $error("flag set without match");

  // ****************************************
  // register checks
  // ****************************************
  property p_ul_lo_write;
    @(posedge mclk) disable iff (rst)
      sfr_wr && sfr_addr == arfwd_pkg::ADDR_UPPER_LIMIT_LOW |=>
        ul_lo == $past(sfr_wdata);
  endproperty
  a_ul_lo_write: assert property (p_ul_lo_write)
    else $error("upper limit low byte write lost");

  property p_ul_hi_write;
    @(posedge mclk) disable iff (rst)
      sfr_wr && sfr_addr == arfwd_pkg::ADDR_UPPER_LIMIT_HIGH |=>
        ul_hi == $past(sfr_wdata);
  endproperty
  a_ul_hi_write: assert property (p_ul_hi_write)
    else $error("upper limit high byte write lost");

  property p_ll_lo_write;
    @(posedge mclk) disable iff (rst)
      sfr_wr && sfr_addr == arfwd_pkg::ADDR_LOWER_LIMIT_LOW |=>
        ll_lo == $past(sfr_wdata);
  endproperty
  a_ll_lo_write: assert property (p_ll_lo_write)
    else $error("lower limit low byte write lost");

  property p_ll_hi_write;
    @(posedge mclk) disable iff (rst)
      sfr_wr && sfr_addr == arfwd_pkg::ADDR_LOWER_LIMIT_HIGH |=>
        ll_hi == $past(sfr_wdata);
  endproperty
  a_ll_hi_write: assert property (p_ll_hi_write)
    else $error("lower limit high byte write lost");

  property p_unmapped;
    @(posedge mclk) disable iff (rst)
      !sfr_hit |-> sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule

//--- tb_adc_result_format_window_detect.sv
`timescale 1ns/1ps
module tb_adc_result_format_window_detect;
  logic        mclk = 0, rst = 1, req = 0, done = 0, d = 0, lj = 0, clr = 0;
  logic        wr, hit, flag, ef = 0;
  logic [7:0]  ra = 0, rd = 0, sa, sd, rdata, hb, lb;
  logic [11:0] code = 0;
  logic [15:0] gt = 16'hffff, lt = 16'h0000, w;
  logic [31:0] seed = 32'h0000_efaf, r, q;
  int          fail_count = 0, tests_run = 0;
  initial forever #25 mclk = ~mclk;
  arfwd_core i_core (.mclk(mclk), .req(req), .req_addr(ra), .req_data(rd),
    .sfr_wr(wr), .sfr_addr(sa), .sfr_wdata(sd));
  arfwd_top i_dut (.mclk(mclk), .rst(rst), .sfr_addr(sa), .sfr_wr(wr),
    .sfr_wdata(sd), .sfr_rdata(rdata), .sfr_hit(hit), .conv_done(done),
    .conv_code(code), .differential(d), .left_justify_select(lj),
    .flag_clear(clr), .result_high_byte(hb), .result_low_byte(lb),
    .window_match_flag(flag));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic match(input logic [15:0] v);
    logic signed [16:0] x, g, l;
    x = {d & v[15], v};
    g = {d & gt[15], gt};
    l = {d & lt[15], lt};
    return (l > g) ? (x < l && x > g) : (x < l || x > g);
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk) ra <= a;
    @(posedge mclk);
    chk({8'h00, rdata}, {8'h00, v});
    chk({15'h0000, hit}, {15'h0000, a[7:2] == 6'h31});
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk) req <= 1;
    ra <= a;
    rd <= v;
    @(posedge mclk) req <= 0;
  endtask
  task lim(input logic [15:0] g, input logic [15:0] l);
    gt = g;
    lt = l;
    wreg(8'hc5, g[15:8]);
    wreg(8'hc4, g[7:0]);
    wreg(8'hc7, l[15:8]);
    wreg(8'hc6, l[7:0]);
    rreg(8'hc5, g[15:8]);
    rreg(8'hc4, g[7:0]);
    rreg(8'hc7, l[15:8]);
    rreg(8'hc6, l[7:0]);
  endtask
  task conv(input logic [11:0] c, input logic k);
    @(negedge mclk);
    done = 1;
    clr = k;
    code = c;
    w = lj ? {c, 4'h0} : {d ? {4{c[11]}} : 4'h0, c};
    ef = (ef & !k) | match(w);
    @(negedge mclk);
    done = 0;
    clr = 0;
    chk({hb, lb}, w);
    chk({15'h0000, flag}, {15'h0000, ef});
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #1_000_000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(negedge mclk);
    rst = 0;
    rreg(8'hc5, 8'hff);
    rreg(8'hc4, 8'hff);
    rreg(8'hc7, 8'h00);
    rreg(8'hc6, 8'h00);
    rreg(8'hc3, 8'h00);
    for (int i = 0; i < 400; i++) begin
      r = rnd();
      @(negedge mclk);
      d = r[12];
      lj = r[13];
      if (r[3:0] == 0) begin
        q = rnd();
        lim(q[15:0], q[31:16]);
      end
      if (r[5:4] == 0) begin
        @(negedge mclk) clr = 1;
        @(negedge mclk) clr = 0;
        ef = 0;
        chk({15'h0000, flag}, 16'h0000);
      end
      conv(r[27:16], r[7:6] == 2'h0);
    end
    report_and_stop();
  end
endmodule
